/* File: core/cpu_core_pkg.sv */
/*
  Constants and types shared by the processor status, register and address block.
  Assumes a classic Wishbone master with 32-bit data and byte addresses.
*/
package cpu_core_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_PSW  = 8'h00;
  localparam logic [7:0] OFF_CMD  = 8'h04;
  localparam logic [7:0] OFF_IP   = 8'h08;
  localparam logic [7:0] OFF_EA   = 8'h0C;
  localparam logic [7:0] OFF_PHYS = 8'h10;
  localparam logic [7:0] OFF_IST  = 8'h14;
  localparam logic [7:0] OFF_IMSK = 8'h18;
  localparam logic [7:0] OFF_IREQ = 8'h1C;
  localparam logic [7:0] OFF_GPR  = 8'h20;
  localparam logic [7:0] OFF_SEG  = 8'h40;
  localparam logic [7:0] OFF_BYTE = 8'h60;
  // Status word bit positions.
  localparam int FLAG_CF = 0;
  localparam int FLAG_PF = 2;
  localparam int FLAG_AF = 4;
  localparam int FLAG_ZF = 6;
  localparam int FLAG_SF = 7;
  localparam int FLAG_TF = 8;
  localparam int FLAG_IF = 9;
  localparam int FLAG_DF = 10;
  localparam int FLAG_OF = 11;
  // Defined status bits; all others hold PSW_FIXED.
  localparam logic [15:0] PSW_DEF_MASK = 16'h0FD5;
  localparam logic [15:0] PSW_FIXED    = 16'h0000;
  localparam logic [15:0] PSW_RESET    = 16'h0000;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  // Command word fields.
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_DST_LSB = 4;
  localparam int CMD_SRC_LSB = 8;
  localparam int CMD_BYTE    = 12;
  // Address control word fields.
  localparam int EA_MODE_LSB = 0;
  localparam int EA_OVR_LSB  = 3;
  localparam int EA_OVR_EN   = 5;
  localparam int EA_STR      = 8;
  localparam int EA_STRB     = 9;
  localparam int EA_DISP_LSB = 16;
  // Interrupt request and status fields.
  localparam int IREQ_GO      = 0;
  localparam int IREQ_VEC_LSB = 8;
  localparam int IST_STEP     = 0;
  localparam int IST_INTR     = 1;
  // Register indices.
  localparam logic [2:0] GPR_BX = 3'd3;
  localparam logic [2:0] GPR_BP = 3'd5;
  localparam logic [2:0] GPR_SI = 3'd6;
  localparam logic [2:0] GPR_DI = 3'd7;
  localparam logic [1:0] SEG_CS = 2'd1;
  localparam logic [1:0] SEG_SS = 2'd2;
  localparam logic [1:0] SEG_DS = 2'd3;

  typedef enum logic [2:0] {
    OP_ADD = 3'b000, OP_ADC = 3'b001, OP_SUB = 3'b010, OP_SBB = 3'b011,
    OP_CMP = 3'b100, OP_AND = 3'b101, OP_OR  = 3'b110, OP_XOR = 3'b111
  } alu_op_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_st_type;
endpackage

/* File: core/cpu_status_flags_and_address_gen.sv */
/*
  Processor status word, general, segment and pointer registers, a flag-setting
  arithmetic unit and segmented address generation behind a Wishbone slave.
  Assumes a classic single-cycle Wishbone master and one clock domain.
*/
// Local design decisions: the Wishbone interface to the registers and the register offsets.
// Function
// - The status word is one sixteen-bit register of result and control flags.
// - Carry in bit 0 is set on carry or borrow at the top bit.
// - Parity in bit 2 is set when the low result byte has even ones.
// - Auxiliary carry in bit 4 marks carry or borrow at the low nibble.
// - Zero in bit 6 is set exactly when the result is zero.
// - Sign in bit 7 copies the top bit of the result.
// - Step trap in bit 8 raises a trap after the next instruction, clearing itself.
// - Maskable interrupts are taken only while bit 9 is set, jumping to the vector.
// - Direction in bit 10 makes string steps decrement, else increment, the index registers.
// - Overflow in bit 11 is set when the signed result does not fit.
// - Eight sixteen-bit general registers; four also split into two byte halves.
// - Four general registers act as base or index in offset calculation.
// - Four sixteen-bit segment registers: code, data, stack and extra.
// - An instruction pointer holds the offset of the next instruction.
// - Memory is addressed by a sixteen-bit segment and sixteen-bit offset pair.
// - Physical address is segment shifted left four plus offset, twenty bits wide.
// - The segment for an operand follows implicitly from the addressing mode.
// - An override replaces the implicit segment for the operand access.
module cpu_status_flags_and_address_gen (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  output logic             irq,
  output logic      [19:0] phys_addr
);
  import cpu_core_pkg::*;

  typedef struct packed {
    bus_st_type       bus;
    logic [31:0]      rdat;
    logic [15:0]      psw;
    logic [7:0][15:0] gpr;
    logic [3:0][15:0] seg;
    logic [15:0]      ip;
    logic [31:0]      ea;
    logic [19:0]      phys;
    logic [15:0]      res;
    logic             resb;
    logic [1:0]       ist;
    logic [1:0]       imsk;
  } state_type;

  state_type   st_q;
  state_type   st_d;
  logic        acc;
  logic        wr;
  logic [31:0] wm;
  logic [31:0] rd;
  logic [15:0] off;
  logic [1:0]  segi;
  logic [19:0] phys_c;
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [21:0] alu_r;
  logic        bm;
  logic [2:0]  dst;
  logic [2:0]  src;
  logic [15:0] stp;
  logic [1:0]  ist_set;
  logic [1:0]  ist_clr;
  logic        op_fire;
  logic        irq_fire;
  logic        str_fire;

  // Expands byte enables into a bit mask.
  function automatic logic [31:0] sel_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Merges masked write data into a sixteen-bit register.
  function automatic logic [15:0] mrg16(input logic [15:0] o, input logic [31:0] d, input logic [31:0] m);
    return (o & ~m[15:0]) | (d[15:0] & m[15:0]);
  endfunction

  // Reads a byte half: indices 0-3 are low halves, 4-7 high halves.
  function automatic logic [7:0] byte_get(input logic [7:0][15:0] g, input logic [2:0] i);
    return i[2] ? g[i[1:0]][15:8] : g[i[1:0]][7:0];
  endfunction

  // Arithmetic unit; returns result and flags {of,sf,zf,af,pf,cf}.
  function automatic logic [21:0] alu(input alu_op_type op, input logic [15:0] a,
                                      input logic [15:0] b, input logic cin, input logic byt);
    logic [16:0] s;
    logic [15:0] r;
    logic        ci;
    logic        c;
    logic        ma;
    logic        mb;
    logic        mr;
    logic        of;
    logic        af;
    logic        lg;
    ci = cin && (op == OP_ADC || op == OP_SBB);
    lg = 1'b0;
    case (op)
      OP_ADD, OP_ADC: s = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
      OP_SUB, OP_SBB, OP_CMP: s = {1'b0, a} - {1'b0, b} - {16'h0000, ci};
      OP_AND: begin
        s = {1'b0, a & b};
        lg = 1'b1;
      end
      OP_OR: begin
        s = {1'b0, a | b};
        lg = 1'b1;
      end
      default: begin
        s = {1'b0, a ^ b};
        lg = 1'b1;
      end
    endcase
    r = byt ? {8'h00, s[7:0]} : s[15:0];
    c = byt ? s[8] : s[16];
    ma = byt ? a[7] : a[15];
    mb = byt ? b[7] : b[15];
    mr = byt ? r[7] : r[15];
    if (op == OP_ADD || op == OP_ADC) begin
      of = (ma == mb) && (mr != ma);
    end else begin
      of = (ma != mb) && (mr != ma);
    end
    af = a[4] ^ b[4] ^ s[4];
    if (lg) begin
      c = 1'b0;
      of = 1'b0;
      af = 1'b0;
    end
    return {r, of, mr, (byt ? (r[7:0] == 8'h00) : (r == 16'h0000)), af, ~^r[7:0], c};
  endfunction

  // Offset, segment choice and physical address of the current operand.
  always_comb begin
    case (st_q.ea[EA_MODE_LSB +: 3])
      3'd0: off = st_q.gpr[GPR_BX] + st_q.gpr[GPR_SI];
      3'd1: off = st_q.gpr[GPR_BX] + st_q.gpr[GPR_DI];
      3'd2: off = st_q.gpr[GPR_BP] + st_q.gpr[GPR_SI];
      3'd3: off = st_q.gpr[GPR_BP] + st_q.gpr[GPR_DI];
      3'd4: off = st_q.gpr[GPR_SI];
      3'd5: off = st_q.gpr[GPR_DI];
      3'd6: off = st_q.gpr[GPR_BP];
      default: off = st_q.gpr[GPR_BX];
    endcase
    off = off + st_q.ea[EA_DISP_LSB +: 16];
    case (st_q.ea[EA_MODE_LSB +: 3])
      3'd2, 3'd3, 3'd6: segi = SEG_SS;
      default: segi = SEG_DS;
    endcase
    if (st_q.ea[EA_OVR_EN]) begin
      segi = st_q.ea[EA_OVR_LSB +: 2];
    end
    phys_c = {st_q.seg[segi], 4'h0} + {4'h0, off};
  end

  // Next-state logic: bus handshake, register writes, arithmetic and interrupts.
  always_comb begin
    st_d = st_q;
    acc = wb_cyc && wb_stb;
    wr = acc && wb_we && (st_q.bus == BUS_ACK);
    wm = sel_mask(wb_sel);
    ist_set = 2'b00;
    ist_clr = 2'b00;
    bm = wb_dat_w[CMD_BYTE];
    dst = wb_dat_w[CMD_DST_LSB +: 3];
    src = wb_dat_w[CMD_SRC_LSB +: 3];
    op_a = bm ? {8'h00, byte_get(st_q.gpr, dst)} : st_q.gpr[dst];
    op_b = bm ? {8'h00, byte_get(st_q.gpr, src)} : st_q.gpr[src];
    alu_r = alu(alu_op_type'(wb_dat_w[CMD_OP_LSB +: 3]), op_a, op_b, st_q.psw[FLAG_CF], bm);
    stp = wb_dat_w[EA_STRB] ? 16'h0001 : 16'h0002;
    rd = 32'h0000_0000;
    if (wb_adr[7:5] == OFF_GPR[7:5]) begin
      rd = {16'h0000, st_q.gpr[wb_adr[4:2]]};
    end else if (wb_adr[7:4] == OFF_SEG[7:4]) begin
      rd = {16'h0000, st_q.seg[wb_adr[3:2]]};
    end else if (wb_adr[7:5] == OFF_BYTE[7:5]) begin
      rd = {24'h000000, byte_get(st_q.gpr, wb_adr[4:2])};
    end else begin
      case (wb_adr)
        OFF_PSW: rd = {16'h0000, st_q.psw};
        OFF_CMD: rd = {15'h0000, st_q.resb, st_q.res};
        OFF_IP: rd = {16'h0000, st_q.ip};
        OFF_EA: rd = st_q.ea;
        OFF_PHYS: rd = {12'h000, st_q.phys};
        OFF_IST: rd = {30'h0000_0000, st_q.ist};
        OFF_IMSK: rd = {30'h0000_0000, st_q.imsk};
        default: rd = 32'h0000_0000;
      endcase
    end
    case (st_q.bus)
      BUS_IDLE: begin
        if (acc) begin
          st_d.bus = BUS_ACK;
          st_d.rdat = rd;
        end
      end
      BUS_ACK: st_d.bus = BUS_IDLE;
      default: st_d.bus = BUS_IDLE;
    endcase
    if (wr) begin
      if (wb_adr[7:5] == OFF_GPR[7:5]) begin
        st_d.gpr[wb_adr[4:2]] = mrg16(st_q.gpr[wb_adr[4:2]], wb_dat_w, wm);
      end else if (wb_adr[7:4] == OFF_SEG[7:4]) begin
        st_d.seg[wb_adr[3:2]] = mrg16(st_q.seg[wb_adr[3:2]], wb_dat_w, wm);
      end else if (wb_adr[7:5] == OFF_BYTE[7:5] && wb_sel[0]) begin
        if (wb_adr[4]) begin
          st_d.gpr[wb_adr[3:2]][15:8] = wb_dat_w[7:0];
        end else begin
          st_d.gpr[wb_adr[3:2]][7:0] = wb_dat_w[7:0];
        end
      end else begin
        case (wb_adr)
          OFF_PSW: st_d.psw = (mrg16(st_q.psw, wb_dat_w, wm) & PSW_DEF_MASK) | PSW_FIXED;
          OFF_CMD: begin
            if (alu_op_type'(wb_dat_w[CMD_OP_LSB +: 3]) != OP_CMP) begin
              if (!bm) begin
                st_d.gpr[dst] = alu_r[21:6];
              end else if (dst[2]) begin
                st_d.gpr[dst[1:0]][15:8] = alu_r[13:6];
              end else begin
                st_d.gpr[dst[1:0]][7:0] = alu_r[13:6];
              end
            end
            st_d.psw[FLAG_CF] = alu_r[0];
            st_d.psw[FLAG_PF] = alu_r[1];
            st_d.psw[FLAG_AF] = alu_r[2];
            st_d.psw[FLAG_ZF] = alu_r[3];
            st_d.psw[FLAG_SF] = alu_r[4];
            st_d.psw[FLAG_OF] = alu_r[5];
            st_d.res = alu_r[21:6];
            st_d.resb = bm;
            st_d.ip = st_q.ip + 16'h0001;
            if (st_q.psw[FLAG_TF]) begin
              st_d.psw[FLAG_TF] = 1'b0;
              ist_set[IST_STEP] = 1'b1;
            end
          end
          OFF_IP: st_d.ip = mrg16(st_q.ip, wb_dat_w, wm);
          OFF_EA: begin
            st_d.ea = (st_q.ea & ~wm) | (wb_dat_w & wm);
            if (wb_dat_w[EA_STR]) begin
              st_d.gpr[GPR_SI] = st_q.psw[FLAG_DF] ? st_q.gpr[GPR_SI] - stp : st_q.gpr[GPR_SI] + stp;
              st_d.gpr[GPR_DI] = st_q.psw[FLAG_DF] ? st_q.gpr[GPR_DI] - stp : st_q.gpr[GPR_DI] + stp;
            end
          end
          OFF_IST: ist_clr = wb_dat_w[1:0] & {2{wb_sel[0]}};
          OFF_IMSK: st_d.imsk = wb_sel[0] ? wb_dat_w[1:0] : st_q.imsk;
          OFF_IREQ: begin
            if (wb_dat_w[IREQ_GO] && st_q.psw[FLAG_IF]) begin
              st_d.ip = {6'h00, wb_dat_w[IREQ_VEC_LSB +: 8], 2'h0};
              st_d.seg[SEG_CS] = 16'h0000;
              st_d.psw[FLAG_IF] = 1'b0;
              st_d.psw[FLAG_TF] = 1'b0;
              ist_set[IST_INTR] = 1'b1;
            end
          end
          default: st_d.ist = st_q.ist;
        endcase
      end
    end
    // A new event wins over a clear in the same cycle.
    st_d.ist = (st_q.ist & ~ist_clr) | ist_set;
    st_d.phys = phys_c;
  end

  // State register with asynchronous reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.psw <= PSW_RESET;
      st_q.ip <= REG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack = (st_q.bus == BUS_ACK);
  assign wb_dat_r = st_q.rdat;
  assign irq = |(st_q.ist & st_q.imsk);
  assign phys_addr = st_q.phys;
  assign op_fire = wr && (wb_adr == OFF_CMD);
  assign irq_fire = wr && (wb_adr == OFF_IREQ) && wb_dat_w[IREQ_GO];
  assign str_fire = wr && (wb_adr == OFF_EA) && wb_dat_w[EA_STR] && (&wb_sel);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_psw_fixed;
    (st_q.psw & ~PSW_DEF_MASK) == PSW_FIXED;
  endproperty
  a_psw_fixed: assert property (p_psw_fixed) else $error("undefined status bits changed");

  property p_zero;
    op_fire |=> st_q.psw[FLAG_ZF] == (st_q.resb ? st_q.res[7:0] == 8'h00 : st_q.res == 16'h0000);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_sign;
    op_fire |=> st_q.psw[FLAG_SF] == (st_q.resb ? st_q.res[7] : st_q.res[15]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");

  property p_parity;
    op_fire |=> st_q.psw[FLAG_PF] == ~^st_q.res[7:0];
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");

  property p_step;
    op_fire && st_q.psw[FLAG_TF] |=> !st_q.psw[FLAG_TF] && st_q.ist[IST_STEP] ##1 irq == st_q.imsk[IST_STEP];
  endproperty
  a_step: assert property (p_step) else $error("step trap not raised");

  property p_ip_next;
    op_fire |=> st_q.ip == $past(st_q.ip) + 16'h0001;
  endproperty
  a_ip_next: assert property (p_ip_next) else $error("ip did not advance");

  property p_intr_masked;
    irq_fire && !st_q.psw[FLAG_IF] |=> $stable(st_q.ip) && !$rose(st_q.ist[IST_INTR]);
  endproperty
  a_intr_masked: assert property (p_intr_masked) else $error("masked interrupt taken");

  property p_dir;
    str_fire && st_q.psw[FLAG_DF] && !wb_dat_w[EA_STRB] |=> st_q.gpr[GPR_SI] == $past(st_q.gpr[GPR_SI]) - 16'h0002;
  endproperty
  a_dir: assert property (p_dir) else $error("string index not decremented");

  property p_dir_up;
    str_fire && !st_q.psw[FLAG_DF] && wb_dat_w[EA_STRB] |=> st_q.gpr[GPR_SI] == $past(st_q.gpr[GPR_SI]) + 16'h0001;
  endproperty
  a_dir_up: assert property (p_dir_up) else $error("string index not incremented");

  // Unsigned word addition carries exactly when the sum wraps below the first operand.
  property p_add_carry;
    op_fire && !bm && alu_op_type'(wb_dat_w[CMD_OP_LSB +: 3]) == OP_ADD
      |=> st_q.psw[FLAG_CF] == (st_q.res < $past(op_a));
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry flag wrong after add");

  property p_logic_clear;
    op_fire && wb_dat_w[CMD_OP_LSB + 2] && wb_dat_w[CMD_OP_LSB +: 2] != 2'h0
      |=> !st_q.psw[FLAG_CF] && !st_q.psw[FLAG_OF];
  endproperty
  a_logic_clear: assert property (p_logic_clear) else $error("logic operation left carry or overflow");

  property p_intr_taken;
    irq_fire && st_q.psw[FLAG_IF]
      |=> st_q.ip == {6'h00, $past(wb_dat_w[IREQ_VEC_LSB +: 8]), 2'h0} && !st_q.psw[FLAG_IF] && st_q.ist[IST_INTR];
  endproperty
  a_intr_taken: assert property (p_intr_taken) else $error("enabled interrupt not taken");

  // Mode 4 without override: data segment base times sixteen plus index and displacement.
  property p_phys;
    st_q.ea[EA_MODE_LSB +: 3] == 3'h4 && !st_q.ea[EA_OVR_EN]
      |=> phys_addr == ({$past(st_q.seg[SEG_DS]), 4'h0}
                        + {4'h0, 16'($past(st_q.gpr[GPR_SI]) + $past(st_q.ea[EA_DISP_LSB +: 16]))});
  endproperty
  a_phys: assert property (p_phys) else $error("physical address wrong");

  property p_ack;
    wb_ack |=> !wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held too long");

  c_step: cover property (op_fire && st_q.psw[FLAG_TF]);
  c_intr: cover property (irq_fire && st_q.psw[FLAG_IF]);
  c_carry: cover property (op_fire ##1 st_q.psw[FLAG_CF] && st_q.psw[FLAG_OF]);
  c_byte: cover property (op_fire && bm);
  c_override: cover property (st_q.ea[EA_OVR_EN] && st_q.ea[EA_OVR_LSB +: 2] == 2'h0);
endmodule

/* File: sim/test_cpu_status_flags_and_address_gen.sv */
/*
  Self-checking bench for the status word, register file and address generator.
  Assumes the register map and one-cycle Wishbone answer of the design, one clock.
*/
module test_cpu_status_flags_and_address_gen;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_core_pkg::*;

  logic        clk;
  logic        rst_b;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        irq;
  logic [19:0] phys_addr;
  logic [31:0] rd_v;
  int          fail_count;
  int          cmp_count;

  cpu_status_flags_and_address_gen i_cpu_status_flags_and_address_gen (
    .clk       (clk),
    .rst_b     (rst_b),
    .wb_cyc    (wb_cyc),
    .wb_stb    (wb_stb),
    .wb_we     (wb_we),
    .wb_adr    (wb_adr),
    .wb_sel    (wb_sel),
    .wb_dat_w  (wb_dat_w),
    .wb_dat_r  (wb_dat_r),
    .wb_ack    (wb_ack),
    .irq       (irq),
    .phys_addr (phys_addr)
  );

  // The 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic results;
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One classic Wishbone cycle; the request holds until ack is seen at an edge.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_sel   <= 4'hF;
    wb_dat_w <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      fail_count++;
      $display("Error %0t: no bus answer at %h", $time, adr);
      results();
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, rd_v);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0000_0000, rd_v);
    chk(rd_v, exp, $sformatf("read at %h", adr));
  endtask

  // Lets the register update land, then looks at the interrupt line.
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp}, "interrupt line");
  endtask

  // Loads operands and carry-in, runs one operation on register 0, checks flags and result.
  task automatic alu_case(input logic [2:0] op, input logic byt, input logic [2:0] src, input logic [15:0] a,
                          input logic [15:0] b, input logic [15:0] pin, input logic [15:0] res, input logic [15:0] psw);
    wr(OFF_GPR, {16'h0000, a});
    wr(OFF_GPR + 8'h04, {16'h0000, b});
    wr(OFF_PSW, {16'h0000, pin});
    wr(OFF_CMD, {19'h0, byt, 1'b0, src, 1'b0, 3'd0, 1'b0, op});
    rd_chk(OFF_PSW, {16'h0000, psw});
    rd_chk(OFF_GPR, {16'h0000, res});
  endtask

  // Sets an addressing control word with displacement 5 and checks both address views.
  task automatic ea_case(input logic [15:0] ctl, input logic [19:0] exp);
    wr(OFF_EA, {16'h0005, ctl});
    rd_chk(OFF_PHYS, {12'h000, exp});
    chk({12'h000, phys_addr}, {12'h000, exp}, "address pin");
  endtask

  // Main sequence: reset, flags, traps, interrupts, addressing, string steps, holes.
  initial begin
    fail_count = 0;
    cmp_count  = 0;
    rst_b    = 1'b0;
    wb_cyc   = 1'b0;
    wb_stb   = 1'b0;
    wb_we    = 1'b0;
    wb_adr   = 8'h00;
    wb_sel   = 4'h0;
    wb_dat_w = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(OFF_PSW, 32'h0000_0000);
    rd_chk(OFF_IP, 32'h0000_0000);
    wr(OFF_PSW, 32'hFFFF_FFFF);
    rd_chk(OFF_PSW, 32'h0000_0FD5);
    alu_case(OP_ADD, 1'b0, 3'd1, 16'hFFFF, 16'h0001, 16'h0000, 16'h0000, 16'h0055);
    alu_case(OP_ADC, 1'b0, 3'd1, 16'h7FFF, 16'h0000, 16'h0001, 16'h8000, 16'h0894);
    alu_case(OP_SUB, 1'b0, 3'd1, 16'h0000, 16'h0001, 16'h0000, 16'hFFFF, 16'h0095);
    alu_case(OP_SBB, 1'b0, 3'd1, 16'h8000, 16'h0000, 16'h0001, 16'h7FFF, 16'h0814);
    alu_case(OP_CMP, 1'b0, 3'd1, 16'h0005, 16'h0005, 16'h0000, 16'h0005, 16'h0044);
    alu_case(OP_AND, 1'b0, 3'd1, 16'hF0F0, 16'h0FF0, 16'h0801, 16'h00F0, 16'h0004);
    alu_case(OP_OR, 1'b0, 3'd1, 16'h8000, 16'h0001, 16'h0000, 16'h8001, 16'h0080);
    alu_case(OP_XOR, 1'b0, 3'd1, 16'h00FF, 16'h00FE, 16'h0000, 16'h0001, 16'h0000);
    alu_case(OP_ADD, 1'b1, 3'd4, 16'h8080, 16'h0000, 16'h0000, 16'h8000, 16'h0845);
    rd_chk(OFF_CMD, 32'h0001_0000);
    rd_chk(OFF_IP, 32'h0000_0009);
    // Step trap: masked first, then unmasked, then cleared.
    wr(OFF_IMSK, 32'h0000_0000);
    wr(OFF_PSW, 32'h0000_0100);
    wr(OFF_CMD, {29'h0, OP_ADD});
    rd_chk(OFF_PSW, 32'h0000_0845);
    rd_chk(OFF_IST, 32'h0000_0001);
    irq_chk(1'b0);
    wr(OFF_IMSK, 32'h0000_0001);
    irq_chk(1'b1);
    wr(OFF_IST, 32'h0000_0001);
    irq_chk(1'b0);
    wr(OFF_BYTE + 8'h10, 32'h0000_005A);
    rd_chk(OFF_GPR, 32'h0000_5A00);
    // Maskable interrupt refused while disabled, taken while enabled.
    wr(OFF_SEG + 8'h04, 32'h0000_1234);
    wr(OFF_PSW, 32'h0000_0000);
    wr(OFF_IREQ, 32'h0000_2101);
    rd_chk(OFF_IP, 32'h0000_000A);
    rd_chk(OFF_IST, 32'h0000_0000);
    wr(OFF_PSW, 32'h0000_0200);
    wr(OFF_IREQ, 32'h0000_2101);
    rd_chk(OFF_IP, 32'h0000_0084);
    rd_chk(OFF_SEG + 8'h04, 32'h0000_0000);
    rd_chk(OFF_PSW, 32'h0000_0000);
    rd_chk(OFF_IST, 32'h0000_0002);
    wr(OFF_IMSK, 32'h0000_0003);
    irq_chk(1'b1);
    wr(OFF_IST, 32'h0000_0002);
    irq_chk(1'b0);
    // Base, index and segment registers for the addressing modes.
    wr(OFF_GPR + 8'h0C, 32'h0000_0010);
    wr(OFF_GPR + 8'h14, 32'h0000_0100);
    wr(OFF_GPR + 8'h18, 32'h0000_0002);
    wr(OFF_GPR + 8'h1C, 32'h0000_0004);
    wr(OFF_SEG, 32'h0000_3000);
    wr(OFF_SEG + 8'h08, 32'h0000_2000);
    wr(OFF_SEG + 8'h0C, 32'h0000_1000);
    ea_case(16'h0000, 20'h10017);
    ea_case(16'h0001, 20'h10019);
    ea_case(16'h0002, 20'h20107);
    ea_case(16'h0003, 20'h20109);
    ea_case(16'h0004, 20'h10007);
    ea_case(16'h0005, 20'h10009);
    ea_case(16'h0006, 20'h20105);
    ea_case(16'h0007, 20'h10015);
    ea_case(16'h0026, 20'h30105);
    wr(OFF_SEG + 8'h0C, 32'h0000_FFFF);
    ea_case(16'h0007, 20'h00005);
    // String steps: byte up with direction clear, word down with it set.
    wr(OFF_PSW, 32'h0000_0000);
    wr(OFF_EA, 32'h0000_0300);
    rd_chk(OFF_GPR + 8'h18, 32'h0000_0003);
    rd_chk(OFF_GPR + 8'h1C, 32'h0000_0005);
    wr(OFF_PSW, 32'h0000_0400);
    wr(OFF_EA, 32'h0000_0100);
    rd_chk(OFF_GPR + 8'h18, 32'h0000_0001);
    rd_chk(OFF_GPR + 8'h1C, 32'h0000_0003);
    // An unmapped address answers with zero and keeps nothing.
    wr(8'h90, 32'hFFFF_FFFF);
    rd_chk(8'h90, 32'h0000_0000);
    results();
  end
endmodule
